// File: design/pin_routing_pkg.sv
// constants for the peripheral pin routing block: codes, indices, keys, resets
// assumes one 10 MHz system clock and no software-visible register bus
package pin_routing_pkg;
  // geometry
  localparam int NUM_PINS = 8; // routed device pins
  localparam int PIN_W = 3; // width of a pin index
  localparam int CODE_W = 6; // width of an output-source code
  localparam int NUM_INPUTS = 4; // peripheral inputs with a pin selection
  localparam int KEY_W = 8; // width of an unlock key write
  // output-source codes
  localparam logic [5:0] CODE_PORT_LATCH = 6'h00; // plain port latch data
  localparam logic [5:0] CODE_OSC1 = 6'h18; // oscillator1_output
  localparam logic [5:0] CODE_PWM6 = 6'h0D; // pwm6_output
  localparam logic [5:0] CODE_PWM7 = 6'h0E; // pwm7_output
  localparam logic [5:0] CODE_SPORT1_CLK = 6'h13; // sync port 1 clock (spi or i2c)
  localparam logic [5:0] CODE_SPORT1_DAT = 6'h14; // sync port 1 data (spi out or i2c)
  localparam logic [5:0] CODE_SPORT2_CLK = 6'h15; // sync port 2 clock (spi or i2c)
  localparam logic [5:0] CODE_SPORT2_DAT = 6'h16; // sync port 2 data (spi out or i2c)
  localparam logic [5:0] CODE_TMR0 = 6'h17; // timer0_output
  localparam logic [5:0] CODE_SERIAL1_CLK = 6'h10; // serial1_sync_clock
  localparam logic [5:0] CODE_SERIAL1_DAT = 6'h11; // serial1_sync_data
  // peripheral input indices
  localparam int IN_SERIAL_RX = 0; // serial_receive_input_select
  localparam int IN_SERIAL_CK = 1; // serial_clock_input_select
  localparam int IN_SPORT_DAT = 2; // sync_port_data_input_select
  localparam int IN_SPORT_CLK = 3; // sync_port_clock_input_select
  // reset values
  localparam logic [5:0] OUT_SEL_RST = 6'h00; // pins start on port latch
  localparam logic [2:0] IN_SEL_RST = 3'h0; // inputs start on pin 0
  // unlock keys, values arbitrary
  localparam logic [7:0] KEY_FIRST = 8'h55; // first key of the sequence
  localparam logic [7:0] KEY_SECOND = 8'hAA; // second key of the sequence
  // lock sequence states
  typedef enum logic [2:0] {
    SEQ_IDLE = 3'b001,
    SEQ_KEY1 = 3'b010,
    SEQ_ARMED = 3'b100
  } lock_seq_t;
endpackage

// File: design/out_sel_bank.sv
// per-pin output-source selection store
// assumes writes are already qualified by the lock logic of its parent
`timescale 1ns/1ps
module out_sel_bank (
  input wire logic mclk, // system clock
  input wire logic rst, // async reset, active high
  input wire logic ce, // clock enable
  input wire logic wr_en, // qualified write strobe
  input wire logic [pin_routing_pkg::PIN_W-1:0] wr_idx, // pin to write
  input wire logic [pin_routing_pkg::CODE_W-1:0] wr_code, // new code
  output logic [pin_routing_pkg::NUM_PINS-1:0][pin_routing_pkg::CODE_W-1:0] sel_q // codes
);
  // one register per pin entry
  genvar gi;
  generate
    for (gi = 0; gi < pin_routing_pkg::NUM_PINS; gi++) begin : g_entry
      // this entry's pin number, cut to index width below
      localparam int ENTRY = gi;
      // entry updates only on a matching write
      always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
          sel_q[gi] <= pin_routing_pkg::OUT_SEL_RST;
        end else if (ce && wr_en && (wr_idx == ENTRY[pin_routing_pkg::PIN_W-1:0])) begin
          sel_q[gi] <= wr_code;
        end
      end
    end
  endgenerate
endmodule

// File: design/peripheral_pin_routing_lock.sv
// peripheral pin routing with selection lock
// assumes peripherals and config writer share mclk; pin_in is asynchronous
// Function
// - output code picks source per pin
// - serial sync clock/data become bidirectional
// - serial and i2c lines treated as pairs
// - i2c lines routable to any pin
// - lock freezes all pin selections
// - lock changes only through key sequence
`timescale 1ns/1ps
module peripheral_pin_routing_lock (
  input wire logic mclk, // system clock, 10 MHz
  input wire logic rst, // async reset, active high
  input wire logic ce, // clock enable, freezes state when low
  input wire logic sel_wr, // selection write strobe
  input wire logic sel_is_input, // 1: input select, 0: output select
  input wire logic [2:0] sel_idx, // pin index or input index
  input wire logic [5:0] sel_code, // output code or pin number
  input wire logic key_wr, // unlock key write strobe
  input wire logic [7:0] key_data, // unlock key value
  input wire logic lock_wr, // lock bit write strobe
  input wire logic lock_val, // new routing_locked_bit value
  input wire logic [7:0] port_latch, // port latch data per pin
  input wire logic [7:0] port_drive, // port latch drive enable per pin
  input wire logic osc1_out, // oscillator1_output
  input wire logic pwm6_out, // pwm6_output
  input wire logic pwm7_out, // pwm7_output
  input wire logic timer0_out, // timer0_output
  input wire logic serial_sync_mode, // serial port in synchronous mode
  input wire logic serial_ck_out, // serial1_sync_clock value
  input wire logic serial_ck_drive, // serial clock driven by port
  input wire logic serial_dt_out, // serial1_sync_data value
  input wire logic serial_dt_drive, // serial data driven by port
  input wire logic sp1_i2c_mode, // sync port 1 in i2c mode
  input wire logic sp1_clk_out, // sync port 1 clock value
  input wire logic sp1_dat_out, // sync port 1 data value
  input wire logic sp2_i2c_mode, // sync port 2 in i2c mode
  input wire logic sp2_clk_out, // sync port 2 clock value
  input wire logic sp2_dat_out, // sync port 2 data value
  input wire logic [7:0] pin_in, // pin levels, asynchronous
  output logic [7:0] pin_out, // pin output value
  output logic [7:0] pin_oe_n, // pin output enable, low drives
  output logic serial_rx_in, // routed serial receive/data input
  output logic serial_ck_in, // routed serial clock input
  output logic sport_dat_in, // routed sync port data input
  output logic sport_clk_in, // routed sync port clock input
  output logic locked, // routing_locked_bit
  output logic wr_ignored // pulse: selection write dropped by lock
);
  localparam int NP = pin_routing_pkg::NUM_PINS; // pin count
  localparam int NI = pin_routing_pkg::NUM_INPUTS; // input count

  logic locked_q; // lock bit state
  pin_routing_pkg::lock_seq_t seq_q; // unlock sequence state
  logic [NP-1:0][pin_routing_pkg::CODE_W-1:0] out_sel; // output codes
  logic [NI-1:0][pin_routing_pkg::PIN_W-1:0] in_sel_q; // input pin selections
  logic out_wr_ok; // accepted output-select write
  logic in_wr_ok; // accepted input-select write
  logic [NP-1:0] sync1_q; // first sync stage
  logic [NP-1:0] sync2_q; // second sync stage
  logic [NP-1:0] sync3_q; // third sync stage
  logic [NP-1:0] pin_filt_q; // settled pin level
  logic [NP-1:0] drv_d; // per-pin drive request
  logic [NP-1:0] val_d; // per-pin value
  logic wr_ignored_q; // ignored-write pulse

  assign out_wr_ok = sel_wr && !sel_is_input && !locked_q;
  assign in_wr_ok = sel_wr && sel_is_input && !locked_q;

  out_sel_bank u_bank (
    .mclk(mclk),
    .rst(rst),
    .ce(ce),
    .wr_en(out_wr_ok),
    .wr_idx(sel_idx),
    .wr_code(sel_code),
    .sel_q(out_sel)
  );

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < NI; i++) begin
        in_sel_q[i] <= pin_routing_pkg::IN_SEL_RST;
      end
    end else if (ce && in_wr_ok && (sel_idx < 3'(NI))) begin
      // low bits of the code carry the pin number
      in_sel_q[sel_idx[1:0]] <= sel_code[2:0];
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      wr_ignored_q <= 1'b0;
    end else if (ce) begin
      wr_ignored_q <= sel_wr && locked_q;
    end
  end

  // key sequence state machine: key1, key2, then lock write, back to back
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      seq_q <= pin_routing_pkg::SEQ_IDLE;
    end else if (ce) begin
      case (seq_q)
        pin_routing_pkg::SEQ_IDLE: begin
          // first key starts the sequence
          if (key_wr && key_data == pin_routing_pkg::KEY_FIRST) begin
            seq_q <= pin_routing_pkg::SEQ_KEY1;
          end
        end
        pin_routing_pkg::SEQ_KEY1: begin
          // second key must follow at once
          if (key_wr && key_data == pin_routing_pkg::KEY_SECOND) begin
            seq_q <= pin_routing_pkg::SEQ_ARMED;
          end else begin
            seq_q <= pin_routing_pkg::SEQ_IDLE;
          end
        end
        pin_routing_pkg::SEQ_ARMED: begin
          // armed for one cycle only
          seq_q <= pin_routing_pkg::SEQ_IDLE;
        end
        default: begin
          seq_q <= pin_routing_pkg::SEQ_IDLE;
        end
      endcase
    end
  end

  // lock bit changes only when armed
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      locked_q <= 1'b0;
    end else if (ce && lock_wr && seq_q == pin_routing_pkg::SEQ_ARMED) begin
      locked_q <= lock_val;
    end
  end

  // per-pin input filter and output routing
  genvar gp;
  generate
    for (gp = 0; gp < NP; gp++) begin : g_pin
      // three-stage synchroniser; change counts when stages two and three agree
      always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
          sync1_q[gp] <= 1'b0;
          sync2_q[gp] <= 1'b0;
          sync3_q[gp] <= 1'b0;
          pin_filt_q[gp] <= 1'b0;
        end else if (ce) begin
          sync1_q[gp] <= pin_in[gp];
          sync2_q[gp] <= sync1_q[gp];
          sync3_q[gp] <= sync2_q[gp];
          if (sync2_q[gp] == sync3_q[gp]) begin
            pin_filt_q[gp] <= sync3_q[gp];
          end
        end
      end

      always_comb begin
        drv_d[gp] = 1'b1;
        val_d[gp] = 1'b0;
        case (out_sel[gp])
          pin_routing_pkg::CODE_OSC1: val_d[gp] = osc1_out;
          pin_routing_pkg::CODE_PWM6: val_d[gp] = pwm6_out;
          pin_routing_pkg::CODE_PWM7: val_d[gp] = pwm7_out;
          pin_routing_pkg::CODE_TMR0: val_d[gp] = timer0_out;
          // serial lines bidirectional in sync mode
          pin_routing_pkg::CODE_SERIAL1_CLK: begin
            val_d[gp] = serial_ck_out;
            drv_d[gp] = serial_sync_mode ? serial_ck_drive : 1'b1;
          end
          pin_routing_pkg::CODE_SERIAL1_DAT: begin
            val_d[gp] = serial_dt_out;
            drv_d[gp] = serial_sync_mode ? serial_dt_drive : 1'b1;
          end
          // i2c pairs open drain, on any pin
          pin_routing_pkg::CODE_SPORT1_CLK: begin
            val_d[gp] = sp1_i2c_mode ? 1'b0 : sp1_clk_out;
            drv_d[gp] = sp1_i2c_mode ? !sp1_clk_out : 1'b1;
          end
          pin_routing_pkg::CODE_SPORT1_DAT: begin
            val_d[gp] = sp1_i2c_mode ? 1'b0 : sp1_dat_out;
            drv_d[gp] = sp1_i2c_mode ? !sp1_dat_out : 1'b1;
          end
          pin_routing_pkg::CODE_SPORT2_CLK: begin
            val_d[gp] = sp2_i2c_mode ? 1'b0 : sp2_clk_out;
            drv_d[gp] = sp2_i2c_mode ? !sp2_clk_out : 1'b1;
          end
          pin_routing_pkg::CODE_SPORT2_DAT: begin
            val_d[gp] = sp2_i2c_mode ? 1'b0 : sp2_dat_out;
            drv_d[gp] = sp2_i2c_mode ? !sp2_dat_out : 1'b1;
          end
          // port latch and unused codes
          default: begin
            val_d[gp] = port_latch[gp];
            drv_d[gp] = port_drive[gp];
          end
        endcase
      end

      // registered pin drive
      always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
          pin_out[gp] <= 1'b0;
          pin_oe_n[gp] <= 1'b1;
        end else if (ce) begin
          pin_out[gp] <= val_d[gp];
          pin_oe_n[gp] <= !drv_d[gp];
        end
      end
    end
  endgenerate

  // inputs read from the selected pin, shared with its output
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      serial_rx_in <= 1'b0;
      serial_ck_in <= 1'b0;
      sport_dat_in <= 1'b0;
      sport_clk_in <= 1'b0;
    end else if (ce) begin
      serial_rx_in <= pin_filt_q[in_sel_q[pin_routing_pkg::IN_SERIAL_RX]];
      serial_ck_in <= pin_filt_q[in_sel_q[pin_routing_pkg::IN_SERIAL_CK]];
      sport_dat_in <= pin_filt_q[in_sel_q[pin_routing_pkg::IN_SPORT_DAT]];
      sport_clk_in <= pin_filt_q[in_sel_q[pin_routing_pkg::IN_SPORT_CLK]];
    end
  end

  assign locked = locked_q;
  assign wr_ignored = wr_ignored_q;

  // checks on lock behaviour and pin routing
  AST_OUT_SEL_FROZEN: assert property (@(posedge mclk) disable iff (rst)
    locked_q && sel_wr && !sel_is_input |=> $stable(out_sel))
    else $error("output selection changed while locked");
  AST_IN_SEL_FROZEN: assert property (@(posedge mclk) disable iff (rst)
    locked_q |=> $stable(in_sel_q))
    else $error("input selection changed while locked");
  AST_LOCK_NEEDS_SEQ: assert property (@(posedge mclk) disable iff (rst)
    !$stable(locked_q) |-> $past(seq_q == pin_routing_pkg::SEQ_ARMED && lock_wr && ce))
    else $error("lock bit changed without key sequence");
  AST_SEQ_FIRST_KEY: assert property (@(posedge mclk) disable iff (rst)
    ce && seq_q == pin_routing_pkg::SEQ_IDLE && key_wr && key_data == pin_routing_pkg::KEY_FIRST
    ##1 ce && key_wr && key_data == pin_routing_pkg::KEY_SECOND
    |=> seq_q == pin_routing_pkg::SEQ_ARMED)
    else $error("two keys did not arm the lock");
  AST_IGNORED_PULSE: assert property (@(posedge mclk) disable iff (rst)
    ce && locked_q && sel_wr |=> wr_ignored)
    else $error("ignored write not flagged");
  AST_NO_FALSE_IGNORE: assert property (@(posedge mclk) disable iff (rst)
    ce && !(locked_q && sel_wr) |=> !wr_ignored)
    else $error("ignored flag raised without a locked write");
  AST_OUT_WRITE_TAKES: assert property (@(posedge mclk) disable iff (rst)
    ce && !locked_q && sel_wr && !sel_is_input |=> out_sel[$past(sel_idx)] == $past(sel_code))
    else $error("unlocked output selection write lost");
  AST_OSC_ROUTE: assert property (@(posedge mclk) disable iff (rst)
    ce && out_sel[0] == pin_routing_pkg::CODE_OSC1 |=> pin_out[0] == $past(osc1_out) && !pin_oe_n[0])
    else $error("oscillator output not routed");
  AST_I2C_OPEN_DRAIN: assert property (@(posedge mclk) disable iff (rst)
    ce && sp1_i2c_mode && out_sel[1] == pin_routing_pkg::CODE_SPORT1_DAT
    |=> !pin_out[1] && pin_oe_n[1] == $past(sp1_dat_out))
    else $error("i2c data not open drain");
  AST_SERIAL_RELEASE: assert property (@(posedge mclk) disable iff (rst)
    ce && serial_sync_mode && !serial_dt_drive && out_sel[2] == pin_routing_pkg::CODE_SERIAL1_DAT
    |=> pin_oe_n[2])
    else $error("serial data pin not released in sync receive");
  AST_RX_ROUTE: assert property (@(posedge mclk) disable iff (rst)
    ce |=> serial_rx_in == $past(pin_filt_q[in_sel_q[pin_routing_pkg::IN_SERIAL_RX]]))
    else $error("receive input not taken from selected pin");
endmodule

// File: testbench/periph_pin_model.sv
// far side of the routing block: the pin wires and an external open-drain device
// assumes the bench drives ext_low; the wire has a pull-up when nobody drives
`timescale 1ns/1ps
module periph_pin_model (
  input wire logic [7:0] pin_out, // routed pin value
  input wire logic [7:0] pin_oe_n, // low while the router drives
  input wire logic [7:0] ext_low, // external device pulls the pin low
  output logic [7:0] pin_in // resolved wire level
);
  // any pin reads back its wire
  // wired level: pull-up, router drive and external pull-down all meet here
  always_comb begin
    pin_in = ~ext_low & (pin_oe_n | pin_out);
  end
endmodule

// File: testbench/peripheral_pin_routing_lock_test.sv
// self-checking bench for the routing block with its lock sequence
// assumes the pin model resolves every wire and feeds it back to pin_in
`timescale 1ns/1ps
module peripheral_pin_routing_lock_test;
  typedef struct {
    logic [5:0] code; logic [3:0] src; logic v; logic m; logic d; logic eo; logic eoe;
  } row_t;
  logic mclk = 0, rst = 1, ce = 1, sel_wr = 0, sel_is_input = 0, key_wr = 0;
  logic lock_wr = 0, lock_val = 0, v = 0, drv = 1, m = 1; // m: sync serial and i2c modes
  logic [2:0] sel_idx = 0; // selected pin or input
  logic [5:0] sel_code = 0; // selection code
  logic [7:0] key_data = 0, ext_low = 0;
  logic [3:0] src = 0; // osc1, pwm6, pwm7, timer0 levels
  logic [7:0] pin_out, pin_oe_n, pin_in;
  logic serial_rx_in, serial_ck_in, sport_dat_in, sport_clk_in, locked, wr_ignored;
  int n_mismatch = 0, n_checks = 0;
  // code, source levels, line value, mode, line drive, expected pin value, expected enable
  row_t rows[16] = '{'{6'h18, 4'h8, 0, 1, 1, 1, 0}, '{6'h0D, 4'h4, 0, 1, 1, 1, 0},
    '{6'h0E, 4'h2, 0, 1, 1, 1, 0}, '{6'h17, 4'h1, 0, 1, 1, 1, 0},
    '{6'h18, 4'h7, 1, 1, 1, 0, 0}, '{6'h13, 4'h0, 0, 1, 1, 0, 0},
    '{6'h10, 4'h0, 1, 1, 1, 1, 0}, '{6'h15, 4'h0, 0, 1, 1, 0, 0},
    '{6'h16, 4'h0, 1, 1, 1, 0, 1}, '{6'h14, 4'h0, 1, 1, 1, 0, 1},
    '{6'h11, 4'h0, 0, 1, 1, 0, 0}, '{6'h00, 4'h0, 1, 1, 1, 1, 1},
    '{6'h3F, 4'h0, 0, 1, 1, 0, 0}, '{6'h13, 4'h0, 1, 0, 1, 1, 0},
    '{6'h11, 4'h0, 1, 0, 0, 1, 0}, '{6'h11, 4'h0, 1, 1, 0, 1, 1}};
  peripheral_pin_routing_lock i_peripheral_pin_routing_lock (.mclk(mclk), .rst(rst), .ce(ce),
    .sel_wr(sel_wr), .sel_is_input(sel_is_input), .sel_idx(sel_idx), .sel_code(sel_code),
    .key_wr(key_wr), .key_data(key_data), .lock_wr(lock_wr), .lock_val(lock_val),
    .port_latch({8{v}}), .port_drive({8{~v}}), .osc1_out(src[3]), .pwm6_out(src[2]),
    .pwm7_out(src[1]), .timer0_out(src[0]), .serial_sync_mode(m), .serial_ck_out(v),
    .serial_ck_drive(drv), .serial_dt_out(v), .serial_dt_drive(drv), .sp1_i2c_mode(m),
    .sp1_clk_out(v), .sp1_dat_out(v), .sp2_i2c_mode(m), .sp2_clk_out(v),
    .sp2_dat_out(v), .pin_in(pin_in), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
    .serial_rx_in(serial_rx_in), .serial_ck_in(serial_ck_in), .sport_dat_in(sport_dat_in),
    .sport_clk_in(sport_clk_in), .locked(locked), .wr_ignored(wr_ignored));
  periph_pin_model i_periph_pin_model (.pin_out(pin_out), .pin_oe_n(pin_oe_n),
    .ext_low(ext_low), .pin_in(pin_in));
  // free-running 10 MHz clock
  initial begin
    forever #50 mclk = ~mclk;
  end
  // compare one value, report and count
  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // one selection write; the refusal pulse shows in the following cycle
  task automatic wr(input logic is_in, input logic [2:0] idx, input logic [5:0] code,
      input logic exp_ign);
    @(posedge mclk);
    sel_wr <= 1;
    sel_is_input <= is_in;
    sel_idx <= idx;
    sel_code <= code;
    @(posedge mclk);
    sel_wr <= 0;
    @(negedge mclk);
    chk("wr_ignored", wr_ignored, exp_ign);
  endtask
  // key, key, lock write; gap 1 breaks the keys apart, gap 2 pauses with ce low
  task automatic seq(input logic [7:0] k2, input int gap, input logic val, input logic exp);
    @(posedge mclk);
    key_wr <= 1;
    key_data <= pin_routing_pkg::KEY_FIRST;
    if (gap != 0) begin
      @(posedge mclk);
      key_wr <= 0;
      ce <= (gap == 1);
    end
    @(posedge mclk);
    ce <= 1;
    key_wr <= 1;
    key_data <= k2;
    @(posedge mclk);
    key_wr <= 0;
    lock_wr <= 1;
    lock_val <= val;
    @(posedge mclk);
    lock_wr <= 0;
    @(negedge mclk);
    chk("locked", locked, exp);
  endtask
  // verdict and end of run
  task automatic summarize();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // watchdog far beyond the fewer than two hundred cycles of the run
  initial begin
    #200000;
    n_mismatch++;
    summarize();
  end
  // main sequence
  initial begin
    repeat (4) @(negedge mclk);
    chk("rst oe_n", pin_oe_n, 8'hFF);
    chk("rst out", pin_out, 8'h00);
    chk("rst lock", {wr_ignored, locked}, 8'h00);
    repeat (4) @(posedge mclk);
    rst <= 0;
    // output codes, one row per pin in turn
    foreach (rows[i]) begin
      @(posedge mclk);
      src <= rows[i].src;
      v <= rows[i].v;
      m <= rows[i].m;
      drv <= rows[i].d;
      wr(0, 3'(i % 8), rows[i].code, 0);
      @(negedge mclk);
      chk("pin_out", pin_out[i % 8], rows[i].eo);
      chk("pin_oe_n", pin_oe_n[i % 8], rows[i].eoe);
    end
    // same pin for input and output of the i2c data line
    @(posedge mclk);
    v <= 1;
    wr(0, 6, pin_routing_pkg::CODE_SPORT1_DAT, 0);
    wr(1, 3'(pin_routing_pkg::IN_SPORT_DAT), 6'h06, 0);
    ext_low <= 8'h40;
    repeat (8) @(negedge mclk);
    chk("sport_dat_in low", sport_dat_in, 0);
    ext_low <= 8'h00;
    repeat (8) @(negedge mclk);
    chk("sport_dat_in high", sport_dat_in, 1);
    // lock attempts: wrong key, gap between keys, then a ce pause
    seq(8'h00, 0, 1, 0);
    seq(pin_routing_pkg::KEY_SECOND, 1, 1, 0);
    seq(pin_routing_pkg::KEY_SECOND, 2, 1, 1);
    wr(0, 0, 6'h00, 1);
    wr(1, 3'(pin_routing_pkg::IN_SPORT_DAT), 6'h00, 1);
    ext_low <= 8'h40;
    repeat (8) @(negedge mclk);
    chk("frozen out", pin_out[0], 0);
    chk("frozen in", sport_dat_in, 0);
    ext_low <= 8'h00;
    seq(pin_routing_pkg::KEY_SECOND, 0, 0, 0);
    wr(0, 0, 6'h00, 0);
    @(negedge mclk);
    chk("unlocked out", pin_out[0], 1);
    // reset in mid-run clears codes and the lock
    seq(pin_routing_pkg::KEY_SECOND, 0, 1, 1);
    @(posedge mclk);
    rst <= 1;
    @(negedge mclk);
    chk("rst2 oe_n", pin_oe_n, 8'hFF);
    chk("rst2 lock", locked, 0);
    // release again: codes back on port latch, every input back on pin 0
    @(posedge mclk);
    rst <= 0;
    repeat (8) @(negedge mclk);
    chk("rst2 pin1", {pin_oe_n[1], pin_out[1]}, 8'h03);
    chk("rst2 inputs", {serial_rx_in, serial_ck_in, sport_dat_in, sport_clk_in}, 8'h0F);
    @(posedge mclk);
    ext_low <= 8'h01;
    repeat (8) @(negedge mclk);
    chk("rst2 inputs low", {serial_rx_in, serial_ck_in, sport_dat_in, sport_clk_in}, 8'h00);
    summarize();
  end
endmodule
